// >>> core/card_uart_pin_control.sv
// card_uart_pin_control: host, subsystem and modem pin control of a card serial controller
// assumes: all pins sampled synchronous to MCLK; open-drain pins resolved outside
`timescale 1ns/100ps
`default_nettype none
// Operation
// - host attribute write completion raises subsystem IRQ
// - attribute read data only while OE low
// - user output low when control bit set
// - user outputs high on reset, loop, clear
// - receiver paced at sixteen times baud rate
// - read input is enable or data strobe
// - REG low selects attribute or I/O space
// - common-memory host cycles are ignored
// - master reset clears controller, unconfigures card
// - ring indicator level in status bit 6
// - ring trailing edge sets status bit 2
// - enabled modem interrupt on ring trailing edge
// - qualified active-low reset, open-drain output
// - RTS active when control bit set
// - RTS high on reset, loop, clear
// - separate select high uses dedicated address pins
// - separate select low multiplexes address/data
// - address bit eight pin in both modes
// - bus style one strobe/direction, zero separate
// - serial input ignored during loopback
module card_uart_pin_control #(
  parameter int ATTR_BYTES = 256,
  parameter int FILTER_CLOCKS = card_uart_pkg::RESET_FILTER_CLOCKS
) (
  input wire logic MCLK, // 25 MHz block clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic [7:0] AWADDR, // AXI write address
  input wire logic AWVALID, // AXI write address valid
  output logic AWREADY, // AXI write address ready
  input wire logic [31:0] WDATA, // AXI write data
  input wire logic [3:0] WSTRB, // AXI write strobes
  input wire logic WVALID, // AXI write data valid
  output logic WREADY, // AXI write data ready
  output logic [1:0] BRESP, // AXI write response
  output logic BVALID, // AXI write response valid
  input wire logic BREADY, // AXI write response ready
  input wire logic [7:0] ARADDR, // AXI read address
  input wire logic ARVALID, // AXI read address valid
  output logic ARREADY, // AXI read address ready
  output logic [31:0] RDATA, // AXI read data
  output logic [1:0] RRESP, // AXI read response
  output logic RVALID, // AXI read data valid
  input wire logic RREADY, // AXI read data ready
  input wire card_uart_pkg::host_bus_s HOST, // host address and strobes
  input wire logic [7:0] HD_IN, // host data in
  output logic [7:0] HD_OUT, // host data out
  output logic HD_OE, // host data drive enable
  input wire logic RESET, // master reset, active high
  output logic RST_OUT_N, // qualified reset, open-drain level
  output logic RST_OUT_OE, // qualified reset pull-down enable
  input wire logic SEPARATE_BUS_SELECT, // 1 separate address bus
  input wire logic BUS_STYLE_SELECT, // 1 strobe/direction, 0 read/write strobes
  input wire logic [7:0] SUB_LOW_ADDR_BUS, // dedicated subsystem address
  input wire logic SUB_ADDR_BIT_EIGHT, // subsystem address bit 8
  input wire logic SUB_ADDR_LATCH, // latch multiplexed address, active high
  input wire logic SUB_READ_STROBE_N, // read enable or data strobe
  input wire logic SUB_WRITE_N, // write enable or read/not-write
  input wire logic [7:0] SUB_ADDR_DATA_BUS_IN, // subsystem address/data in
  output logic [7:0] SUB_ADDR_DATA_BUS_OUT, // subsystem data out
  output logic SUB_ADDR_DATA_BUS_OE, // subsystem data drive enable
  output logic SUB_IRQ, // host attribute write seen, active high
  output logic MODEM_INT, // modem status interrupt, active high
  output logic RTS_N, // request to send, active low
  output logic DTR_N, // terminal ready, active low
  output logic USER_OUTPUT_ONE_N, // open-drain level
  output logic USER_OUTPUT_ONE_OE, // pull-down enable
  output logic USER_OUTPUT_TWO_N, // open-drain level
  output logic USER_OUTPUT_TWO_OE, // pull-down enable
  input wire logic RI_N, // ring indicator, active low
  input wire logic SERIAL_IN, // serial line data
  input wire logic RCLK // 16x receive clock, sampled
);
  import card_uart_pkg::*;

  // ---------------------------------------------------------------------------
  // reset qualification
  // ---------------------------------------------------------------------------
  logic master_reset, srst_n;

  master_reset_filter #(.STABLE_CLOCKS(FILTER_CLOCKS)) u_filter (
    .clk(MCLK),
    .rst_n(RST_N),
    .raw(RESET),
    .qualified(master_reset)
  );

  assign srst_n = RST_N & ~master_reset;

  // fail-safe: the pin only ever pulls low, never drives high
  always_ff @(posedge MCLK) begin
    RST_OUT_N <= 1'b0;
    RST_OUT_OE <= RST_N & master_reset;
  end

  // ---------------------------------------------------------------------------
  // state and attribute memory
  // ---------------------------------------------------------------------------
  logic [7:0] attr_mem [ATTR_BYTES];
  modem_ctrl_s modem_control_reg;
  logic [3:0] int_enable;
  logic ring_trailing_edge_flag, ri_last, rx_done, rclk_last, rx_tick;
  logic [8:0] rx_word;
  logic [7:0] rx_byte, modem_status_reg;

  assign modem_status_reg = {1'b0, ~RI_N, 3'b000, ring_trailing_edge_flag, 2'b00};

  // ---------------------------------------------------------------------------
  // host side
  // ---------------------------------------------------------------------------
  logic host_sel, host_attr_rd, host_io_rd, we_last, iowr_last, host_attr_done, host_io_done, host_msr_read;
  logic [7:0] host_attr_idx;

  assign host_sel = ~HOST.reg_n & ~HOST.ce_n;
  assign host_attr_rd = host_sel & ~HOST.oe_n & ~HOST.addr[0];
  assign host_io_rd = host_sel & ~HOST.iord_n;
  assign host_attr_idx = HOST.addr[8:1];
  assign host_attr_done = host_sel & ~HOST.addr[0] & ~HOST.addr[9] & ~we_last & HOST.we_n;
  assign host_io_done = host_sel & iowr_last & ~HOST.iowr_n;
  assign host_msr_read = host_io_rd & (HOST.addr[2:0] == HOST_IO_STA) & ~HD_OE;

  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      we_last <= 1'b1;
      iowr_last <= 1'b1;
    end else begin
      we_last <= HOST.we_n;
      iowr_last <= HOST.iowr_n;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      HD_OUT <= 8'h00;
      HD_OE <= 1'b0;
    end else begin
      HD_OE <= host_attr_rd | host_io_rd;
      if (host_attr_rd) begin
        HD_OUT <= HOST.addr[9] ? 8'h00 : attr_mem[host_attr_idx];
      end else if (host_io_rd && HOST.addr[2:0] == HOST_IO_CTL) begin
        HD_OUT <= {3'b000, modem_control_reg};
      end else if (host_io_rd && HOST.addr[2:0] == HOST_IO_STA) begin
        HD_OUT <= modem_status_reg;
      end else begin
        HD_OUT <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // subsystem side
  // ---------------------------------------------------------------------------
  logic [7:0] sub_latched_addr;
  logic [8:0] sub_addr;
  logic sub_rd, sub_wr, sub_wr_last;

  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      sub_latched_addr <= 8'h00;
    end else if (SUB_ADDR_LATCH && !SEPARATE_BUS_SELECT) begin
      sub_latched_addr <= SUB_ADDR_DATA_BUS_IN;
    end
  end

  assign sub_addr = {SUB_ADDR_BIT_EIGHT,
                     SEPARATE_BUS_SELECT ? SUB_LOW_ADDR_BUS : sub_latched_addr};

  always_comb begin
    if (BUS_STYLE_SELECT) begin
      sub_rd = ~SUB_READ_STROBE_N & SUB_WRITE_N;
      sub_wr = ~SUB_READ_STROBE_N & ~SUB_WRITE_N;
    end else begin
      sub_rd = ~SUB_READ_STROBE_N;
      sub_wr = ~SUB_WRITE_N;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      sub_wr_last <= 1'b0;
      SUB_ADDR_DATA_BUS_OUT <= 8'h00;
      SUB_ADDR_DATA_BUS_OE <= 1'b0;
    end else begin
      sub_wr_last <= sub_wr;
      SUB_ADDR_DATA_BUS_OE <= sub_rd;
      SUB_ADDR_DATA_BUS_OUT <= sub_addr[8] ? 8'h00 : attr_mem[sub_addr[7:0]];
    end
  end

  // host write wins when both sides finish a write in the same cycle
  always_ff @(posedge MCLK) begin
    if (host_attr_done) begin
      attr_mem[host_attr_idx] <= HD_IN;
    end else if (sub_wr_last && !sub_wr && !sub_addr[8]) begin
      attr_mem[sub_addr[7:0]] <= SUB_ADDR_DATA_BUS_IN;
    end
  end

  // ---------------------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      rclk_last <= 1'b0;
      rx_tick <= 1'b0;
    end else begin
      rclk_last <= RCLK;
      rx_tick <= RCLK & ~rclk_last;
    end
  end

  serial_receiver #(.OVERSAMPLE(OVERSAMPLE)) u_rx (
    .clk(MCLK),
    .rst_n(srst_n),
    .tick(rx_tick),
    .line(modem_control_reg.loop ? 1'b1 : SERIAL_IN),
    .data(rx_byte),
    .done(rx_done)
  );

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic aw_held, w_held, do_write, axi_msr_read, axi_rx_read;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign do_write = aw_held & w_held & ~BVALID;
  assign axi_msr_read = ARVALID & ARREADY & (ARADDR == OFS_MODEM_STATUS);
  assign axi_rx_read = ARVALID & ARREADY & (ARADDR == OFS_RX_DATA);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        wr_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        wr_data <= WDATA;
        wr_strb <= WSTRB;
        WREADY <= 1'b0;
      end
      if (do_write) begin
        BVALID <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        if (wr_addr == OFS_MODEM_CONTROL || wr_addr == OFS_INT_ENABLE || wr_addr == OFS_SUB_IRQ) begin
          BRESP <= RESP_OKAY;
        end else begin
          BRESP <= RESP_SLVERR;
        end
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RRESP <= RESP_OKAY;
        if (ARADDR == OFS_MODEM_CONTROL) begin
          RDATA <= {27'h0, modem_control_reg};
        end else if (ARADDR == OFS_MODEM_STATUS) begin
          RDATA <= {24'h0, modem_status_reg};
        end else if (ARADDR == OFS_INT_ENABLE) begin
          RDATA <= {28'h0, int_enable};
        end else if (ARADDR == OFS_RX_DATA) begin
          RDATA <= {23'h0, rx_word};
        end else if (ARADDR == OFS_SUB_IRQ) begin
          RDATA <= {31'h0, SUB_IRQ};
        end else if (ARADDR == OFS_PIN_STATUS) begin
          RDATA <= {29'h0, BUS_STYLE_SELECT, SEPARATE_BUS_SELECT, master_reset};
        end else begin
          RDATA <= 32'h0000_0000;
          RRESP <= RESP_SLVERR;
        end
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  // host I/O write and software write may collide; software wins
  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      modem_control_reg <= CTL_RESET;
      int_enable <= IER_RESET;
    end else begin
      if (host_io_done && HOST.addr[2:0] == HOST_IO_CTL) begin
        modem_control_reg <= HD_IN[4:0];
      end
      if (do_write && wr_strb[0] && wr_addr == OFS_MODEM_CONTROL) begin
        modem_control_reg <= wr_data[4:0];
      end
      if (do_write && wr_strb[0] && wr_addr == OFS_INT_ENABLE) begin
        int_enable <= wr_data[3:0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      rx_word <= 9'h000;
    end else if (rx_done) begin
      rx_word <= {1'b1, rx_byte};
    end else if (axi_rx_read) begin
      rx_word[RXD_VALID] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // events: set beats a same-cycle clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      ri_last <= 1'b1;
      ring_trailing_edge_flag <= 1'b0;
      SUB_IRQ <= 1'b0;
      MODEM_INT <= 1'b0;
    end else begin
      ri_last <= RI_N;
      if (!ri_last && RI_N) begin
        ring_trailing_edge_flag <= 1'b1;
      end else if (axi_msr_read || host_msr_read) begin
        ring_trailing_edge_flag <= 1'b0;
      end
      MODEM_INT <= ring_trailing_edge_flag & int_enable[IER_MODEM];
      if (host_attr_done) begin
        SUB_IRQ <= 1'b1;
      end else if (do_write && wr_strb[0] && wr_addr == OFS_SUB_IRQ && wr_data[0]) begin
        SUB_IRQ <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // modem and user outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!srst_n) begin
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      USER_OUTPUT_ONE_N <= 1'b0;
      USER_OUTPUT_ONE_OE <= 1'b0;
      USER_OUTPUT_TWO_N <= 1'b0;
      USER_OUTPUT_TWO_OE <= 1'b0;
    end else begin
      RTS_N <= ~(modem_control_reg.rts & ~modem_control_reg.loop);
      DTR_N <= ~(modem_control_reg.dtr & ~modem_control_reg.loop);
      USER_OUTPUT_ONE_N <= 1'b0;
      USER_OUTPUT_TWO_N <= 1'b0;
      USER_OUTPUT_ONE_OE <= modem_control_reg.usr1 & ~modem_control_reg.loop;
      USER_OUTPUT_TWO_OE <= modem_control_reg.usr2 & ~modem_control_reg.loop;
    end
  end
endmodule : card_uart_pin_control
`default_nettype wire

// >>> core/card_uart_pkg.sv
// card_uart_pkg: constants and types shared by the card serial pin-control block
// assumes: compiled before every file under core/
package card_uart_pkg;

  // ---------------------------------------------------------------------------
  // software register byte offsets (AXI4-Lite)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h08;
  localparam logic [7:0] OFS_RX_DATA = 8'h0C;
  localparam logic [7:0] OFS_SUB_IRQ = 8'h10;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h14;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int IER_MODEM = 3;
  localparam int RXD_VALID = 8;

  // ---------------------------------------------------------------------------
  // reset values, host I/O indexes, bus answers
  // ---------------------------------------------------------------------------
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [2:0] HOST_IO_CTL = 3'h4;
  localparam logic [2:0] HOST_IO_STA = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int RESET_FILTER_CLOCKS = 8;
  localparam int OVERSAMPLE = 16;

  typedef struct packed {
    logic loop;
    logic usr2;
    logic usr1;
    logic rts;
    logic dtr;
  } modem_ctrl_s;

  typedef struct packed {
    logic [9:0] addr;
    logic reg_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
  } host_bus_s;

endpackage : card_uart_pkg

// >>> core/master_reset_filter.sv
// master_reset_filter: qualifies the active-high master reset input
// assumes: input synchronous to clk; output level changes only after a stable run
`timescale 1ns/100ps
`default_nettype none
module master_reset_filter #(
  parameter int STABLE_CLOCKS = 8
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic raw, // unfiltered master reset
  output logic qualified // filtered master reset level
);
  logic last;
  logic [$clog2(STABLE_CLOCKS+1)-1:0] run;

  // glitches shorter than the window never reach the output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last <= 1'b0;
      run <= '0;
      qualified <= 1'b0;
    end else begin
      last <= raw;
      if (raw != last) begin
        run <= '0;
      end else if (run != STABLE_CLOCKS[$bits(run)-1:0]) begin
        run <= run + 1'b1;
      end
      if (run == STABLE_CLOCKS[$bits(run)-1:0] - 1'b1) begin
        qualified <= last;
      end
    end
  end
endmodule : master_reset_filter
`default_nettype wire

// >>> core/serial_receiver.sv
// serial_receiver: 8N1 receiver paced by a 16x receive-clock tick
// assumes: tick is a one-cycle pulse per receive-clock rising edge
`timescale 1ns/100ps
`default_nettype none
module serial_receiver #(
  parameter int OVERSAMPLE = 16
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic tick, // one pulse per oversample period
  input wire logic line, // serial line, idle high
  output logic [7:0] data, // last received byte
  output logic done // one-cycle pulse, byte complete
);
  logic busy;
  logic [3:0] phase;
  logic [3:0] bitno;
  logic [7:0] shift;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      phase <= '0;
      bitno <= '0;
      shift <= '0;
      data <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        if (!busy) begin
          if (!line) begin
            busy <= 1'b1;
            phase <= '0;
            bitno <= '0;
          end
        end else begin
          phase <= phase + 1'b1;
          // sample at mid-bit; a false start bit is dropped there
          if (phase == 4'(OVERSAMPLE / 2 - 1)) begin
            if (bitno == 4'h0 && line) begin
              busy <= 1'b0;
            end else if (bitno == 4'h9) begin
              busy <= 1'b0;
              data <= shift;
              done <= line;
            end else if (bitno != 4'h0) begin
              shift <= {line, shift[7:1]};
            end
          end
          if (phase == 4'(OVERSAMPLE - 1)) begin
            bitno <= bitno + 1'b1;
          end
        end
      end
    end
  end
endmodule : serial_receiver
`default_nettype wire

// >>> test/card_host_model.sv
// card_host_model: behavioural card host controller on the host pins
// assumes: cycle() called from the bench, one host cycle at a time
`timescale 1ns/100ps
`default_nettype none
module card_host_model (
  input wire logic MCLK, // clock
  output var card_uart_pkg::host_bus_s HOST, // address, strobes
  output logic [7:0] HD_IN, // write data
  input wire logic [7:0] HD_OUT, // read data
  input wire logic HD_OE // device drives
);
  import card_uart_pkg::*;
  initial HOST = '{addr: 10'h000, default: 1'b1};
  initial HD_IN = 8'h00;
  // released data shows the inverse, never a stale match
  task automatic cycle(input logic reg_lvl, input logic io, input logic wr, input logic [9:0] a,
      input logic [7:0] dat, output logic [7:0] q);
    @(posedge MCLK);
    HOST <= '{addr: a, reg_n: reg_lvl, ce_n: 1'b0, default: 1'b1};
    HD_IN <= dat;
    @(posedge MCLK);
    HOST.we_n <= !(wr && !io);
    HOST.iowr_n <= !(wr && io);
    HOST.oe_n <= !(!wr && !io);
    HOST.iord_n <= !(!wr && io);
    repeat (3) @(posedge MCLK);
    q = (HD_OE === 1'b1) ? HD_OUT : 8'hZZ;
    HOST <= '{addr: a, reg_n: reg_lvl, ce_n: 1'b0, default: 1'b1};
    @(posedge MCLK);
    HOST <= '{addr: ~a, default: 1'b1};
    HD_IN <= ~dat;
  endtask : cycle
endmodule : card_host_model
`default_nettype wire

// >>> test/card_uart_pin_control_sva.sv
// card_uart_pin_control_sva: port-level checks of the card serial pin-control block
// assumes: bound to card_uart_pin_control, default filter length of eight clocks
`timescale 1ns/100ps
`default_nettype none
module card_uart_pin_control_sva (
  input wire logic MCLK, // clock
  input wire logic RST_N, // reset
  input wire card_uart_pkg::host_bus_s HOST, // host strobes
  input wire logic HD_OE, // host drive
  input wire logic SUB_READ_STROBE_N, // sub read
  input wire logic SUB_ADDR_DATA_BUS_OE, // sub drive
  input wire logic RESET, // master reset
  input wire logic RST_OUT_OE, // reset out
  input wire logic SUB_IRQ, // sub irq
  input wire logic RTS_N, // rts
  input wire logic DTR_N, // dtr
  input wire logic USER_OUTPUT_ONE_OE, // out one
  input wire logic USER_OUTPUT_TWO_OE // out two
);
  import card_uart_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_host_drive_cause: assert property (HD_OE |-> $past(!HOST.reg_n && !HOST.ce_n && !(HOST.oe_n && HOST.iord_n)))
    else $error("host data driven without a read");
  chk_host_drive_drop: assert property (HOST.oe_n && HOST.iord_n |=> !HD_OE)
    else $error("host data still driven");
  chk_sub_drive_cause: assert property (SUB_ADDR_DATA_BUS_OE |-> $past(!SUB_READ_STROBE_N))
    else $error("sub data driven without a read");
  chk_sub_drive_drop: assert property ($rose(SUB_READ_STROBE_N) |=> !SUB_ADDR_DATA_BUS_OE)
    else $error("sub data still driven");
  chk_rst_out_set: assert property (RESET [*8] |-> ##[1:3] RST_OUT_OE)
    else $error("reset out not asserted");
  chk_rst_out_clear: assert property (!RESET [*8] |-> ##[1:3] !RST_OUT_OE)
    else $error("reset out not released");
  chk_reset_quiet: assert property (RST_OUT_OE [*2] |-> RTS_N && DTR_N && !USER_OUTPUT_ONE_OE && !USER_OUTPUT_TWO_OE && !SUB_IRQ)
    else $error("outputs active in master reset");
  chk_irq_set: assert property ($rose(HOST.we_n) && !HOST.reg_n && !HOST.ce_n && !HOST.addr[9] && !HOST.addr[0] && !RST_OUT_OE
      |-> ##[1:2] SUB_IRQ)
    else $error("no irq after attribute write");
  cover property ($rose(SUB_IRQ));
  cover property ($rose(HD_OE));
  cover property ($rose(RST_OUT_OE));
endmodule : card_uart_pin_control_sva
bind card_uart_pin_control card_uart_pin_control_sva chk (.*);
`default_nettype wire

// >>> test/testbench.sv
// testbench: self-checking bench for the card serial pin-control block
// assumes: core/ package and design compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import card_uart_pkg::*;
  logic RST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, RESET = 1'b0;
  logic SEPARATE_BUS_SELECT = 1'b0, BUS_STYLE_SELECT = 1'b0, SUB_ADDR_BIT_EIGHT = 1'b0, SUB_ADDR_LATCH = 1'b0;
  logic SUB_READ_STROBE_N = 1'b1, SUB_WRITE_N = 1'b1, RI_N = 1'b1, SERIAL_IN = 1'b1, MCLK = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, SUB_LOW_ADDR_BUS = 8'h00, SUB_ADDR_DATA_BUS_IN = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] rc = 2'h0, r, BRESP, RRESP;
  logic [7:0] HD_IN, HD_OUT, SUB_ADDR_DATA_BUS_OUT, q;
  logic [5:0] e;
  host_bus_s HOST;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, HD_OE, RST_OUT_N, RST_OUT_OE, SUB_ADDR_DATA_BUS_OE, SUB_IRQ;
  logic MODEM_INT, RTS_N, DTR_N, USER_OUTPUT_ONE_N, USER_OUTPUT_ONE_OE, USER_OUTPUT_TWO_N, USER_OUTPUT_TWO_OE, RCLK;
  int bad_count = 0, num_checks = 0, cycles = 0;
  assign RCLK = rc[1];
  card_uart_pin_control DUT (.*);
  card_host_model host (.*);
  initial forever #20 MCLK = ~MCLK;
  // receive clock four block clocks long, one tick per period
  always @(posedge MCLK) begin
    rc <= rc + 2'h1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    resp = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    v = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask : rd
  task automatic sub_rd(input logic sep, input logic sty, input logic [8:0] a, output logic [7:0] v);
    @(posedge MCLK);
    SEPARATE_BUS_SELECT <= sep;
    BUS_STYLE_SELECT <= sty;
    SUB_ADDR_BIT_EIGHT <= a[8];
    SUB_LOW_ADDR_BUS <= sep ? a[7:0] : ~a[7:0];
    SUB_ADDR_DATA_BUS_IN <= a[7:0];
    SUB_ADDR_LATCH <= !sep;
    @(posedge MCLK);
    SUB_ADDR_LATCH <= 1'b0;
    SUB_ADDR_DATA_BUS_IN <= ~a[7:0];
    SUB_READ_STROBE_N <= 1'b0;
    idle(3);
    v = (SUB_ADDR_DATA_BUS_OE === 1'b1) ? SUB_ADDR_DATA_BUS_OUT : 8'hZZ;
    SUB_READ_STROBE_N <= 1'b1;
  endtask : sub_rd
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      SERIAL_IN <= f[i];
      idle(64);
    end
  endtask : send
  task automatic t_regs();
    rd(8'h18, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    wr(OFS_MODEM_STATUS, 32'h0, r);
    chk("read-only resp", RESP_SLVERR, r);
    for (int i = 0; i < 32; i++) begin
      wr(OFS_MODEM_CONTROL, i, r);
      idle(3);
      e = i[4] ? 6'h03 : {2'h0, i[3], i[2], ~i[1], ~i[0]};
      chk("modem pins", e, {USER_OUTPUT_ONE_N, USER_OUTPUT_TWO_N, USER_OUTPUT_TWO_OE, USER_OUTPUT_ONE_OE, RTS_N, DTR_N});
    end
    $display("test registers done");
  endtask : t_regs
  task automatic t_host();
    host.cycle(1'b0, 1'b0, 1'b1, 10'h010, 8'hA5, q);
    idle(2);
    chk("sub irq", 1, SUB_IRQ);
    host.cycle(1'b0, 1'b0, 1'b0, 10'h010, 8'h00, q);
    chk("attr read", 8'hA5, q);
    host.cycle(1'b1, 1'b0, 1'b0, 10'h010, 8'h00, q);
    chk("common read", 8'hZZ, q);
    host.cycle(1'b0, 1'b1, 1'b1, {7'h0, HOST_IO_CTL}, 8'h02, q);
    host.cycle(1'b1, 1'b1, 1'b1, {7'h0, HOST_IO_CTL}, 8'h00, q);
    chk("io rts", 0, RTS_N);
    wr(OFS_SUB_IRQ, 32'h1, r);
    idle(2);
    chk("irq cleared", 0, SUB_IRQ);
    $display("test host done");
  endtask : t_host
  task automatic t_sub();
    logic [2:0] m [4] = '{3'h4, 3'h0, 3'h2, 3'h5};
    for (int i = 0; i < 4; i++) begin
      sub_rd(m[i][2], m[i][1], {m[i][0], 8'h08}, q);
      chk("sub read", m[i][0] ? 8'h00 : 8'hA5, q);
    end
    $display("test subsystem done");
  endtask : t_sub
  task automatic t_ring();
    wr(OFS_INT_ENABLE, 32'h8, r);
    RI_N <= 1'b0;
    idle(4);
    rd(OFS_MODEM_STATUS, d, r);
    chk("ring level", 32'h40, d & 32'h44);
    RI_N <= 1'b1;
    idle(6);
    chk("modem int", 1, MODEM_INT);
    rd(OFS_MODEM_STATUS, d, r);
    chk("ring edge", 32'h04, d & 32'h44);
    rd(OFS_MODEM_STATUS, d, r);
    chk("ring edge clear", 32'h0, d & 32'h44);
    $display("test ring done");
  endtask : t_ring
  task automatic t_rx();
    send(8'h3C);
    idle(40);
    rd(OFS_RX_DATA, d, r);
    chk("rx byte", 32'h13C, d & 32'h1FF);
    wr(OFS_MODEM_CONTROL, 32'h10, r);
    send(8'h00);
    idle(40);
    rd(OFS_RX_DATA, d, r);
    chk("rx in loop", 32'h0, d & 32'h100);
    $display("test receive done");
  endtask : t_rx
  task automatic t_mreset();
    wr(OFS_MODEM_CONTROL, 32'h0F, r);
    RESET <= 1'b1;
    idle(12);
    chk("reset out", 1, RST_OUT_OE);
    chk("reset pins", 4'hC, {RTS_N, DTR_N, USER_OUTPUT_ONE_OE, USER_OUTPUT_TWO_OE});
    RESET <= 1'b0;
    idle(12);
    rd(OFS_MODEM_CONTROL, d, r);
    chk("mcr cleared", 32'h0, d & 32'h1F);
    $display("test master reset done");
  endtask : t_mreset
  initial begin
    idle(20);
    RST_N <= 1'b1;
    idle(2);
    t_regs();
    t_host();
    t_sub();
    t_ring();
    t_rx();
    t_mreset();
    summarize();
  end
endmodule : testbench
`default_nettype wire
